//--- hw/opa_pkg.sv
// Constants and types shared by the one-time-programmable access controller
// Operation
// [R1] Wait 20 us after pin reset
// [R2] Write 0x04 to device control first
// [R3] Program entry: 0x40, 0x58, then voltage
// [R4] Device increments pointer after each data write
// [R5] Poll completion by address read per byte
// [R6] Device shows an error status bit
// [R7] Program exit: voltage off, 0x40, 0x00
// [R8] Finish with device control 0x02, 0x00
// [R9] Read mode 0x00; each read increments pointer
// [R10] Read exit: 0x40 then 0x00
// [R11] Locations program once, only with voltage
// [R12] Lock flags follow the addressed location
// [R13] Upper security nibble zero blocks writes
// [R14] Lower security nibble zero blocks reads
// [R15] Checksum engine works despite locks
// [R16] Block checksum covers aligned 256 bytes
// [R17] Checksum byte one write starts 32-bit
// [R18] Busy flag set during checksum run
// [R19] 32-bit polynomial 0x04C11DB7, byte 3 first
// [R20] Checksum byte zero write starts block
// [R21] 16-bit polynomial 0x1021, byte 1 first
// [R22] Reset before 32-bit after block checksum
package opa_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RST_WAIT_US = 20;
  localparam int RST_WAIT_CYC =
    (RST_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POLL_LIMIT = 1023;
  // Device register indices on the link
  localparam logic [7:0] REG_DEV_CTL = 8'h02;
  localparam logic [7:0] REG_PROM_CTL = 8'h10;
  localparam logic [7:0] REG_ADDR_HI = 8'h11;
  localparam logic [7:0] REG_ADDR_LO = 8'h12;
  localparam logic [7:0] REG_DATA = 8'h13;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CSUM0 = 8'h20;
  localparam logic [7:0] REG_CSUM1 = 8'h21;
  // Control values written to the device
  localparam logic [7:0] DEVICE_CONTROL_REG_CORE_HOLD = 8'h04;
  localparam logic [7:0] DEVICE_CONTROL_REG_RESET = 8'h02;
  localparam logic [7:0] DEVICE_CONTROL_REG_RUN = 8'h00;
  localparam logic [7:0] PCTL_PREP = 8'h40;
  localparam logic [7:0] PCTL_PROG = 8'h58;
  localparam logic [7:0] PCTL_READ = 8'h00;
  localparam logic [7:0] PCTL_OFF = 8'h00;
  // Bit positions in the link address and status registers
  localparam int BUSY_BIT = 1;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_READ_LOCK_FLAG_BIT = 4;
  localparam int STAT_WRITE_LOCK_FLAG_BIT = 5;
  typedef enum logic [1:0] {
    OPA_OP_WRITE, OPA_OP_READ, OPA_OP_CRC16, OPA_OP_CRC32
  } opa_op_t;
  typedef enum logic [1:0] {
    KIND_WR, KIND_RD, KIND_ARD, KIND_POLL
  } opa_kind_t;
endpackage

//--- hw/opa_step_if.sv
// Step request channel between sequencer and link access engine
`timescale 1ns/10ps
interface opa_step_if;
  logic req;
  opa_pkg::opa_kind_t kind;
  logic [7:0] reg_sel;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  logic timeout;
  modport ctrl(output req, kind, reg_sel, wdata,
               input done, rdata, timeout);
  modport port(input req, kind, reg_sel, wdata,
               output done, rdata, timeout);
endinterface

//--- hw/opa_timer.sv
// Down-counter giving one pulse after a loaded number of cycles
`timescale 1ns/10ps
module opa_timer #(
  parameter int W = 16
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic start, // Load and start
  input wire logic [W-1:0] load, // Cycles to run
  output logic done // Pulse on expiry
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic done_q;
  logic done_d;

  // Restart wins over a running count
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = load;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
      done_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
endmodule

//--- hw/opa_link_port.sv
// Link access engine: one register access per step, busy polling built in
`timescale 1ns/10ps
module opa_link_port #(
  parameter int POLL_LIMIT = opa_pkg::POLL_LIMIT
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  opa_step_if.port stp, // Steps from the sequencer
  output logic link_req, // Access request to device
  output logic [1:0] link_kind, // Access kind
  output logic [7:0] link_reg, // Device register
  output logic [7:0] link_wdata, // Write data
  input wire logic link_ack, // Access finished
  input wire logic [7:0] link_rdata // Read data
);
  typedef enum logic [1:0] {LP_IDLE, LP_WAIT, LP_GAP} opa_lp_t;
  opa_lp_t st_q;
  opa_lp_t st_d;
  logic req_q, req_d, poll_q, poll_d, done_q, done_d, tmo_q, tmo_d;
  logic [1:0] kind_q, kind_d;
  logic [7:0] reg_q, reg_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic [15:0] tries_q, tries_d;
  logic still_busy;

  assign still_busy = poll_q && link_rdata[opa_pkg::BUSY_BIT];

  // Accept a step, hold the request until acknowledged, repeat polls
  always_comb begin
    st_d = st_q;
    req_d = req_q;
    poll_d = poll_q;
    kind_d = kind_q;
    reg_d = reg_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    tries_d = tries_q;
    tmo_d = tmo_q;
    done_d = 1'b0;
    case (st_q)
      LP_IDLE: begin
        if (stp.req) begin
          poll_d = (stp.kind == opa_pkg::KIND_POLL);
          kind_d = poll_d ? opa_pkg::KIND_ARD : stp.kind;
          reg_d = stp.reg_sel;
          wdata_d = stp.wdata;
          tries_d = 16'h0000;
          tmo_d = 1'b0;
          req_d = 1'b1;
          st_d = LP_WAIT;
        end
      end
      LP_WAIT: begin
        if (link_ack) begin
          req_d = 1'b0;
          rdata_d = link_rdata;
          // A bounded poll keeps a dead device from hanging the host
          if (still_busy && tries_q < 16'(POLL_LIMIT - 1)) begin
            tries_d = tries_q + 16'h0001; // [R5]
            st_d = LP_GAP;
          end else begin
            tmo_d = still_busy;
            done_d = 1'b1;
            st_d = LP_IDLE;
          end
        end
      end
      LP_GAP: begin
        req_d = 1'b1; // [R5]
        st_d = LP_WAIT;
      end
      default: st_d = LP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= LP_IDLE;
      req_q <= 1'b0;
      poll_q <= 1'b0;
      kind_q <= 2'h0;
      reg_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      tries_q <= 16'h0000;
      tmo_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      poll_q <= poll_d;
      kind_q <= kind_d;
      reg_q <= reg_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      tries_q <= tries_d;
      tmo_q <= tmo_d;
      done_q <= done_d;
    end
  end

  assign link_req = req_q;
  assign link_kind = kind_q;
  assign link_reg = reg_q;
  assign link_wdata = wdata_q;
  assign stp.done = done_q;
  assign stp.rdata = rdata_q;
  assign stp.timeout = tmo_q;

  property p_poll_again;
    @(posedge clk) disable iff (rst)
    (st_q == LP_WAIT && link_ack && still_busy &&
     tries_q < 16'(POLL_LIMIT - 1))
    |=> !link_req ##1 (link_req && link_kind == opa_pkg::KIND_ARD);
  endproperty
  a_poll_again: assert property (p_poll_again) // [R5]
    else $error("busy poll not repeated");
endmodule

//--- hw/opa_ctrl.sv
// Programmer-side sequencer for write, read and checksum sessions
`timescale 1ns/10ps
module opa_ctrl #(
  parameter int WAIT_CYCLES = opa_pkg::RST_WAIT_CYC,
  parameter int POLL_LIMIT = opa_pkg::POLL_LIMIT
) (
  input wire logic SYS_CLK, // 250 MHz clock
  input wire logic RST, // Synchronous reset, high
  input wire logic CMD_VALID, // Command offered
  output logic CMD_READY, // Command taken when both high
  input wire logic [1:0] CMD_OP, // Operation code
  input wire logic [15:0] CMD_ADDR, // Start address or block
  input wire logic [15:0] CMD_COUNT, // Bytes to move
  input wire logic WR_VALID, // Program byte offered
  output logic WR_READY, // Program byte taken
  input wire logic [7:0] WR_DATA, // Program byte
  output logic RD_VALID, // Read byte pulse
  output logic [7:0] RD_DATA, // Read byte
  output logic DONE, // Session end pulse
  output logic ERROR, // Last session failed
  output logic BUSY, // Session running
  output logic [31:0] RESULT, // Checksum result
  output logic DEV_RST_N, // Device reset pin, low
  output logic VPP_EN, // Programming voltage on
  output logic LINK_REQ, // Link access request
  output logic [1:0] LINK_KIND, // Link access kind
  output logic [7:0] LINK_REG, // Device register
  output logic [7:0] LINK_WDATA, // Link write data
  input wire logic LINK_ACK, // Link access done
  input wire logic [7:0] LINK_RDATA // Link read data
);
  typedef enum logic [4:0] {
    ST_IDLE, ST_PIN_RST, ST_PIN_WAIT, ST_CORE, ST_MODE1, ST_MODE2,
    ST_VPP_ON, ST_ADDR_HI, ST_ADDR_LO, ST_DATA_GET, ST_DATA_WR, ST_POLL,
    ST_DATA_RD, ST_STAT, ST_CRC_GO, ST_CRC_POLL, ST_CRC_RD, ST_VPP_OFF,
    ST_EXIT1, ST_EXIT2, ST_DEVR1, ST_DEVR2
  } opa_st_t;

  opa_step_if stp();
  opa_st_t st_q, st_d;
  opa_pkg::opa_op_t op_q, op_d;
  logic [15:0] addr_q, addr_d, cnt_q, cnt_d;
  logic [7:0] wbyte_q, wbyte_d, rd_data_q, rd_data_d;
  logic [31:0] res_q, res_d;
  logic [1:0] idx_q, idx_d;
  logic issued_q, issued_d, err_q, err_d, vpp_q, vpp_d, pin_q, pin_d;
  logic rd_valid_q, rd_valid_d, done_q, done_d;
  logic step_need, tmr_start, tmr_done, is_wr, is_crc, bad;
  logic [15:0] tmr_load;

  assign is_wr = (op_q == opa_pkg::OPA_OP_WRITE);
  assign is_crc = (op_q == opa_pkg::OPA_OP_CRC16) ||
                  (op_q == opa_pkg::OPA_OP_CRC32);
  assign bad = stp.rdata[opa_pkg::STAT_ERR_BIT] ||
               (is_wr ? stp.rdata[opa_pkg::STAT_WRITE_LOCK_FLAG_BIT]
                      : stp.rdata[opa_pkg::STAT_READ_LOCK_FLAG_BIT]);

  // Link step wanted in each state
  always_comb begin
    step_need = 1'b1;
    stp.kind = opa_pkg::KIND_WR;
    stp.reg_sel = opa_pkg::REG_DEV_CTL;
    stp.wdata = opa_pkg::DEVICE_CONTROL_REG_RUN;
    case (st_q)
      ST_CORE: stp.wdata = opa_pkg::DEVICE_CONTROL_REG_CORE_HOLD; // [R2]
      ST_MODE1: begin
        stp.reg_sel = opa_pkg::REG_PROM_CTL;
        stp.wdata = is_wr ? opa_pkg::PCTL_PREP // [R3]
                          : opa_pkg::PCTL_READ; // [R9]
      end
      ST_MODE2: begin
        stp.reg_sel = opa_pkg::REG_PROM_CTL;
        stp.wdata = opa_pkg::PCTL_PROG; // [R3]
      end
      ST_ADDR_HI: begin
        stp.reg_sel = opa_pkg::REG_ADDR_HI;
        stp.wdata = addr_q[15:8];
      end
      ST_ADDR_LO: begin
        stp.reg_sel = opa_pkg::REG_ADDR_LO;
        stp.wdata = addr_q[7:0];
      end
      ST_DATA_WR: begin
        stp.reg_sel = opa_pkg::REG_DATA;
        stp.wdata = wbyte_q;
      end
      ST_POLL, ST_CRC_POLL: stp.kind = opa_pkg::KIND_POLL; // [R5]
      ST_DATA_RD: begin
        stp.kind = opa_pkg::KIND_RD;
        stp.reg_sel = opa_pkg::REG_DATA;
      end
      ST_STAT: begin
        stp.kind = opa_pkg::KIND_RD;
        stp.reg_sel = opa_pkg::REG_STATUS;
      end
      ST_CRC_GO: begin
        // Block start is a page number, so alignment cannot be broken
        stp.reg_sel = (op_q == opa_pkg::OPA_OP_CRC16) ?
                      opa_pkg::REG_CSUM0 : opa_pkg::REG_CSUM1;
        stp.wdata = addr_q[15:8];
      end
      ST_CRC_RD: begin
        stp.kind = opa_pkg::KIND_RD;
        stp.reg_sel = opa_pkg::REG_CSUM0 + {6'h00, idx_q};
      end
      ST_EXIT1: begin
        stp.reg_sel = opa_pkg::REG_PROM_CTL;
        stp.wdata = opa_pkg::PCTL_PREP; // [R7] [R10]
      end
      ST_EXIT2: begin
        stp.reg_sel = opa_pkg::REG_PROM_CTL;
        stp.wdata = opa_pkg::PCTL_OFF; // [R7] [R10]
      end
      ST_DEVR1: stp.wdata = opa_pkg::DEVICE_CONTROL_REG_RESET; // [R8]
      ST_DEVR2: stp.wdata = opa_pkg::DEVICE_CONTROL_REG_RUN; // [R8]
      default: step_need = 1'b0;
    endcase
  end

  assign stp.req = step_need && !issued_q;

  // Session sequencer
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    wbyte_d = wbyte_q;
    rd_data_d = rd_data_q;
    res_d = res_q;
    idx_d = idx_q;
    err_d = err_q;
    vpp_d = vpp_q;
    pin_d = pin_q;
    rd_valid_d = 1'b0;
    done_d = 1'b0;
    tmr_start = 1'b0;
    tmr_load = 16'(opa_pkg::RST_PULSE_CYC);
    issued_d = step_need && !stp.done && (issued_q || stp.req);
    case (st_q)
      ST_IDLE: begin
        if (CMD_VALID) begin
          op_d = opa_pkg::opa_op_t'(CMD_OP);
          addr_d = CMD_ADDR;
          cnt_d = CMD_COUNT;
          res_d = 32'h0000_0000;
          err_d = 1'b0;
          pin_d = 1'b1; // Every session opens with a pin reset [R22]
          tmr_start = 1'b1;
          st_d = ST_PIN_RST;
        end
      end
      ST_PIN_RST: begin
        if (tmr_done) begin
          pin_d = 1'b0;
          tmr_start = 1'b1;
          tmr_load = 16'(WAIT_CYCLES); // [R1]
          st_d = ST_PIN_WAIT;
        end
      end
      ST_PIN_WAIT: if (tmr_done) st_d = ST_CORE; // [R1]
      ST_CORE: if (stp.done) st_d = is_crc ? ST_CRC_GO : ST_MODE1;
      ST_MODE1: if (stp.done) st_d = is_wr ? ST_MODE2 : ST_ADDR_HI;
      ST_MODE2: if (stp.done) st_d = ST_VPP_ON;
      ST_VPP_ON: begin
        vpp_d = 1'b1; // [R3]
        st_d = ST_ADDR_HI;
      end
      ST_ADDR_HI: if (stp.done) st_d = ST_ADDR_LO;
      ST_ADDR_LO: begin
        if (stp.done) begin
          if (cnt_q == 16'h0000) begin
            st_d = is_wr ? ST_VPP_OFF : ST_EXIT1;
          end else begin
            st_d = is_wr ? ST_DATA_GET : ST_DATA_RD;
          end
        end
      end
      ST_DATA_GET: begin
        if (WR_VALID) begin
          wbyte_d = WR_DATA;
          st_d = ST_DATA_WR;
        end
      end
      ST_DATA_WR: begin
        if (stp.done) begin
          addr_d = addr_q + 16'h0001; // Mirrors device pointer [R4]
          st_d = ST_POLL; // [R5]
        end
      end
      ST_POLL: begin
        if (stp.done) begin
          err_d = stp.timeout;
          st_d = stp.timeout ? ST_VPP_OFF : ST_STAT;
        end
      end
      ST_DATA_RD: begin
        if (stp.done) begin
          rd_data_d = stp.rdata;
          addr_d = addr_q + 16'h0001; // [R9]
          st_d = ST_STAT;
        end
      end
      ST_STAT: begin
        if (stp.done) begin
          // A bad status aborts; the byte read with it is withheld
          if (bad) begin
            err_d = 1'b1;
            st_d = is_wr ? ST_VPP_OFF : ST_EXIT1;
          end else begin
            rd_valid_d = !is_wr;
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              st_d = is_wr ? ST_VPP_OFF : ST_EXIT1;
            end else begin
              st_d = is_wr ? ST_DATA_GET : ST_DATA_RD;
            end
          end
        end
      end
      ST_CRC_GO: begin
        if (stp.done) begin
          idx_d = (op_q == opa_pkg::OPA_OP_CRC16) ? 2'h1 : 2'h3;
          st_d = ST_CRC_POLL;
        end
      end
      ST_CRC_POLL: begin
        if (stp.done) begin
          err_d = stp.timeout;
          st_d = stp.timeout ? ST_DEVR1 : ST_CRC_RD;
        end
      end
      ST_CRC_RD: begin
        if (stp.done) begin
          res_d = {res_q[23:0], stp.rdata}; // Most significant first
          idx_d = idx_q - 2'h1;
          if (idx_q == 2'h0) st_d = ST_DEVR1;
        end
      end
      ST_VPP_OFF: begin
        vpp_d = 1'b0; // Voltage drops before mode exit [R7]
        st_d = ST_EXIT1;
      end
      ST_EXIT1: if (stp.done) st_d = ST_EXIT2;
      ST_EXIT2: if (stp.done) st_d = ST_DEVR1;
      ST_DEVR1: if (stp.done) st_d = ST_DEVR2;
      ST_DEVR2: begin
        if (stp.done) begin
          done_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_q <= ST_IDLE;
      op_q <= opa_pkg::OPA_OP_WRITE;
      addr_q <= 16'h0000;
      cnt_q <= 16'h0000;
      wbyte_q <= 8'h00;
      rd_data_q <= 8'h00;
      res_q <= 32'h0000_0000;
      idx_q <= 2'h0;
      issued_q <= 1'b0;
      err_q <= 1'b0;
      vpp_q <= 1'b0;
      pin_q <= 1'b0;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      wbyte_q <= wbyte_d;
      rd_data_q <= rd_data_d;
      res_q <= res_d;
      idx_q <= idx_d;
      issued_q <= issued_d;
      err_q <= err_d;
      vpp_q <= vpp_d;
      pin_q <= pin_d;
      rd_valid_q <= rd_valid_d;
      done_q <= done_d;
    end
  end

  opa_timer #(.W(16)) u_timer (
    .clk(SYS_CLK),
    .rst(RST),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done)
  );

  opa_link_port #(.POLL_LIMIT(POLL_LIMIT)) u_link (
    .clk(SYS_CLK),
    .rst(RST),
    .stp(stp.port),
    .link_req(LINK_REQ),
    .link_kind(LINK_KIND),
    .link_reg(LINK_REG),
    .link_wdata(LINK_WDATA),
    .link_ack(LINK_ACK),
    .link_rdata(LINK_RDATA)
  );

  assign CMD_READY = (st_q == ST_IDLE);
  assign WR_READY = (st_q == ST_DATA_GET);
  assign BUSY = (st_q != ST_IDLE);
  assign RD_VALID = rd_valid_q;
  assign RD_DATA = rd_data_q;
  assign DONE = done_q;
  assign ERROR = err_q;
  assign RESULT = res_q;
  assign DEV_RST_N = !pin_q;
  assign VPP_EN = vpp_q;

  // Observers of the pins, read only by the checks below
  logic [15:0] since_q, since_d;
  logic [7:0] last_q, last_d, prev_q, prev_d;
  logic core_q, core_d, blk_q, blk_d, wr_ack;
  assign wr_ack = LINK_REQ && LINK_ACK && LINK_KIND == opa_pkg::KIND_WR;
  always_comb begin
    since_d = since_q;
    last_d = last_q;
    prev_d = prev_q;
    core_d = core_q;
    blk_d = blk_q;
    if (!DEV_RST_N) begin
      since_d = 16'h0000;
      last_d = 8'h00;
      prev_d = 8'h00;
      core_d = 1'b0;
      blk_d = 1'b0;
    end else begin
      if (since_q != 16'hffff) since_d = since_q + 16'h0001;
      if (wr_ack && LINK_REG == opa_pkg::REG_PROM_CTL) begin
        prev_d = last_q;
        last_d = LINK_WDATA;
      end
      if (wr_ack && LINK_REG == opa_pkg::REG_DEV_CTL &&
          LINK_WDATA == opa_pkg::DEVICE_CONTROL_REG_CORE_HOLD) core_d = 1'b1;
      if (wr_ack && LINK_REG == opa_pkg::REG_CSUM0) blk_d = 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      since_q <= 16'h0000;
      last_q <= 8'h00;
      prev_q <= 8'h00;
      core_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      since_q <= since_d;
      last_q <= last_d;
      prev_q <= prev_d;
      core_q <= core_d;
      blk_q <= blk_d;
    end
  end

  property p_first_wait;
    @(posedge SYS_CLK) disable iff (RST)
    $rose(LINK_REQ) |-> since_q >= 16'(WAIT_CYCLES);
  endproperty
  a_first_wait: assert property (p_first_wait) // [R1]
    else $error("link used too soon after pin reset");

  property p_core_first;
    @(posedge SYS_CLK) disable iff (RST)
    (LINK_REQ && LINK_REG == opa_pkg::REG_PROM_CTL) |-> core_q;
  endproperty
  a_core_first: assert property (p_core_first) // [R2]
    else $error("memory control written before core hold");

  property p_vpp_entry;
    @(posedge SYS_CLK) disable iff (RST)
    $rose(VPP_EN) |-> (last_q == opa_pkg::PCTL_PROG &&
                       prev_q == opa_pkg::PCTL_PREP);
  endproperty
  a_vpp_entry: assert property (p_vpp_entry) // [R3]
    else $error("voltage applied before program mode entry");

  property p_addr_step;
    @(posedge SYS_CLK) disable iff (RST)
    ((st_q == ST_DATA_WR || st_q == ST_DATA_RD) && stp.done)
    |=> addr_q == $past(addr_q) + 16'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step) // [R4]
    else $error("address copy did not advance by one");

  property p_poll_after;
    @(posedge SYS_CLK) disable iff (RST)
    (wr_ack && LINK_REG == opa_pkg::REG_DATA)
    |-> ##[1:8] (LINK_REQ && LINK_KIND == opa_pkg::KIND_ARD);
  endproperty
  a_poll_after: assert property (p_poll_after) // [R5]
    else $error("no completion poll after data write");

  property p_vpp_exit;
    @(posedge SYS_CLK) disable iff (RST)
    (LINK_REQ && LINK_REG == opa_pkg::REG_PROM_CTL &&
     last_q == opa_pkg::PCTL_PROG) |-> !VPP_EN;
  endproperty
  a_vpp_exit: assert property (p_vpp_exit) // [R7]
    else $error("mode exit while voltage still on");

  property p_dev_reset;
    @(posedge SYS_CLK) disable iff (RST)
    (wr_ack && LINK_REG == opa_pkg::REG_DEV_CTL &&
     LINK_WDATA == opa_pkg::DEVICE_CONTROL_REG_RESET)
    |-> ##[1:8] (LINK_REQ && LINK_REG == opa_pkg::REG_DEV_CTL &&
                 LINK_WDATA == opa_pkg::DEVICE_CONTROL_REG_RUN);
  endproperty
  a_dev_reset: assert property (p_dev_reset) // [R8]
    else $error("device reset not followed by release");

  property p_read_mode;
    @(posedge SYS_CLK) disable iff (RST)
    (st_q == ST_DATA_RD && stp.req) |-> last_q == opa_pkg::PCTL_READ;
  endproperty
  a_read_mode: assert property (p_read_mode) // [R9]
    else $error("data read outside read mode");

  property p_mode_exit;
    @(posedge SYS_CLK) disable iff (RST)
    (LINK_REQ && !is_crc && LINK_REG == opa_pkg::REG_DEV_CTL &&
     LINK_WDATA == opa_pkg::DEVICE_CONTROL_REG_RESET)
    |-> (last_q == opa_pkg::PCTL_OFF && prev_q == opa_pkg::PCTL_PREP);
  endproperty
  a_mode_exit: assert property (p_mode_exit) // [R10]
    else $error("device reset before mode exit pair");

  property p_crc32_clean;
    @(posedge SYS_CLK) disable iff (RST)
    (LINK_REQ && LINK_KIND == opa_pkg::KIND_WR &&
     LINK_REG == opa_pkg::REG_CSUM1) |-> !blk_q;
  endproperty
  a_crc32_clean: assert property (p_crc32_clean) // [R22]
    else $error("full checksum without reset after block one");
endmodule

//--- testbench/opa_dev_model.sv
// Behavioural device: link registers, code memory, locks, checksum bytes
`timescale 1ns/10ps
module opa_dev_model (
  input wire logic clk, // System clock
  input wire logic rstn, // Device reset pin, low
  input wire logic req, // Access request
  input wire logic [1:0] kind, // Access kind
  input wire logic [7:0] rsel, // Register index
  input wire logic [7:0] wd, // Write data
  input wire logic vpp, // Programming voltage
  input wire logic [7:0] sec, // Security byte
  input wire logic [3:0] dly, // Extra answer cycles
  output logic ack = 1'b0, // Access done
  output logic [7:0] rd, // Read data
  output logic bad = 1'b0 // Sticky order fault
);
  localparam logic [31:0] CSUM = 32'h1a2b3c4d;
  logic [7:0] mem [0:255];
  logic [15:0] ptr = 16'h0;
  logic [7:0] pg = 8'h0, junk = 8'h0;
  logic [3:0] wt = 4'h0;
  logic [1:0] bsy = 2'h0;
  logic hold = 1'b0, pm = 1'b0, fail = 1'b0, wl, rl;
  int gap = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign wl = sec[7:4] != 4'hf;
  assign rl = sec[3:0] != 4'hf;
  // Read data is valid only with ack; a moving pattern otherwise
  always_comb begin
    rd = junk;
    if (ack && kind == 2'h2) rd = {6'h0, bsy != 2'h0, 1'b0};
    else if (ack && rsel == 8'h13) rd = rl ? 8'h00 : mem[ptr[7:0]];
    else if (ack && rsel == 8'h14) rd = {2'h0, wl, rl, 3'h0, fail};
    else if (ack && rsel[7:2] == 6'h08)
      rd = CSUM[rsel[1:0]*8 +: 8] ^ (~|rsel[1:0] ? pg : 8'h0);
  end
  // Slow or prompt answers; one ack per request
  always @(posedge clk) begin
    junk <= junk + 8'h3b;
    gap <= rstn ? gap + 1 : 0;
    wt <= (req && !ack) ? wt + 4'h1 : 4'h0;
    ack <= req && !ack && wt >= dly;
    if (!rstn) fail <= 1'b0; // Pin reset clears the write error
    if ((req && gap < 20) || (vpp && !pm)) bad <= 1'b1;
    if (req && ack && kind == 2'h2 && bsy != 2'h0) bsy <= bsy - 2'h1;
    if (req && ack && kind == 2'h1 && rsel == 8'h13) ptr <= ptr + 16'h1;
    if (req && ack && kind == 2'h0) begin
      if (rsel == 8'h13 && (!pm || !vpp || bsy != 2'h0)) bad <= 1'b1;
      if (rsel[7:4] == 4'h2 && !hold) bad <= 1'b1;
      if (rsel == 8'h10 && vpp) bad <= 1'b1;
      case (rsel)
        8'h02: hold <= wd == 8'h04;
        8'h10: pm <= wd == 8'h58 && hold;
        8'h11: ptr[15:8] <= wd;
        8'h12: ptr[7:0] <= wd;
        8'h13: begin
          // A used location refuses the byte and raises the error bit
          fail <= mem[ptr[7:0]] != 8'hff;
          if (vpp && !wl && mem[ptr[7:0]] == 8'hff) begin
            mem[ptr[7:0]] <= wd;
          end
          ptr <= ptr + 16'h1;
          bsy <= 2'h2;
        end
        8'h20: begin
          pg <= wd;
          bsy <= 2'h3;
        end
        8'h21: begin
          pg <= 8'h0;
          bsy <= 2'h3;
        end
        default: ;
      endcase
    end
  end
endmodule

//--- testbench/otp_program_read_crc_access_tb.sv
// Self-checking bench for the access controller against the device model
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  fail_count++; $display("Error %0t got %h exp %h", $time, a, e); end end
module otp_program_read_crc_access_tb;
  typedef struct {logic [1:0] op; logic [15:0] a, n; logic [7:0] s, b;
    logic e; logic [31:0] r;} opa_row_t;
  logic clk = 1'b0, rst = 1'b1, cv = 1'b0, wv = 1'b0;
  logic [1:0] op = 2'h0, lk;
  logic [15:0] ad = 16'h0, cn = 16'h0;
  logic [7:0] wd = 8'h0, sec = 8'hff, rdd, lrd, lreg, lwd;
  logic [3:0] dl = 4'h0;
  logic cr, wr, rv, dn, er, bz, rn, vpp, lrq, lak, bad;
  logic [31:0] res;
  int fail_count = 0, comparisons = 0;
  // Program, read back, locked checksums, then each lock refusing access
  opa_row_t rows[6] = '{
    '{2'h0, 16'h0, 16'h2, 8'hff, 8'ha0, 1'b0, 32'h0},
    '{2'h1, 16'h0, 16'h2, 8'hff, 8'ha0, 1'b0, 32'h0},
    '{2'h2, 16'h0200, 16'h0, 8'h00, 8'h0, 1'b0, 32'h3c4f},
    '{2'h3, 16'h0, 16'h0, 8'h00, 8'h0, 1'b0, 32'h1a2b3c4d},
    '{2'h0, 16'h10, 16'h1, 8'h0f, 8'h11, 1'b1, 32'h0},
    '{2'h1, 16'h0, 16'h1, 8'hf0, 8'h0, 1'b1, 32'h0}};
  always #2 clk = ~clk;
  opa_ctrl #(.WAIT_CYCLES(20), .POLL_LIMIT(8)) dut_u (.SYS_CLK(clk),
    .RST(rst), .CMD_VALID(cv), .CMD_READY(cr), .CMD_OP(op), .CMD_ADDR(ad),
    .CMD_COUNT(cn), .WR_VALID(wv), .WR_READY(wr), .WR_DATA(wd),
    .RD_VALID(rv), .RD_DATA(rdd), .DONE(dn), .ERROR(er), .BUSY(bz),
    .RESULT(res), .DEV_RST_N(rn), .VPP_EN(vpp), .LINK_REQ(lrq),
    .LINK_KIND(lk), .LINK_REG(lreg), .LINK_WDATA(lwd), .LINK_ACK(lak),
    .LINK_RDATA(lrd));
  opa_dev_model dev_u (.clk(clk), .rstn(rn), .req(lrq), .kind(lk),
    .rsel(lreg), .wd(lwd), .vpp(vpp), .sec(sec), .dly(dl), .ack(lak),
    .rd(lrd), .bad(bad));
  task finish_test;
    $display("Mismatches %0d of %0d checks", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One session; bytes offered as base plus index, read bytes compared
  task run(input logic [1:0] o, input logic [15:0] a, n,
    input logic [7:0] b);
    int i, j, k;
    logic t;
    i = 0;
    j = 0;
    op = o;
    ad = a;
    cn = n;
    cv = 1'b1;
    @(posedge clk);
    #1 cv = 1'b0;
    for (k = 0; k < 3000 && dn !== 1'b1; k++) begin
      wv = wr;
      wd = b + i[7:0];
      t = wr;
      @(posedge clk);
      #1;
      if (t === 1'b1) i++;
      if (rv === 1'b1) begin
        `CHK(rdd, b + j[7:0])
        j++;
      end
    end
    wv = 1'b0;
    `CHK(dn, 1'b1)
    if (er !== 1'b1 && o[1] == 1'b0) `CHK(16'(o[0] ? j : i), n)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    `CHK({cr, bz, rn, vpp, lrq, dn}, 6'b101000)
    foreach (rows[x]) begin
      sec = rows[x].s;
      dl = x[3:0];
      run(rows[x].op, rows[x].a, rows[x].n, rows[x].b);
      `CHK(er, rows[x].e)
      if (rows[x].op == 2'h2) `CHK(res[15:0], rows[x].r[15:0])
      if (rows[x].op == 2'h3) `CHK(res, rows[x].r)
    end
    // Reset cut into a session; commands offered while busy are ignored
    op = 2'h1;
    cv = 1'b1;
    repeat (10) @(posedge clk);
    #1 cv = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    `CHK({cr, bz, rn, vpp, lrq, dn}, 6'b101000)
    // A used location keeps its first value and reports an error
    sec = 8'hff;
    run(2'h0, 16'h0, 16'h1, 8'h55);
    `CHK(er, 1'b1)
    run(2'h1, 16'h0, 16'h1, 8'ha0);
    `CHK(bad, 1'b0)
    finish_test;
  end
  // Sessions need well under a thousand cycles each
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    finish_test;
  end
endmodule
